// ===== common/dtc_pkg.sv
// Package for the dual timer/counter block
package dtc_pkg;
  // ********************
  // Register addresses
  // ********************
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_LO0 = 8'h8A;
  localparam logic [7:0] ADDR_LO1 = 8'h8B;
  localparam logic [7:0] ADDR_HI0 = 8'h8C;
  localparam logic [7:0] ADDR_HI1 = 8'h8D;
  localparam logic [7:0] ADDR_DIV = 8'h8E;
  // ********************
  // Reset values
  // ********************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  // ********************
  // Field positions
  // ********************
  localparam int CTRL_OVF1 = 7;
  localparam int CTRL_RUN1 = 6;
  localparam int CTRL_OVF0 = 5;
  localparam int CTRL_RUN0 = 4;
  localparam int NIB_GATE = 3;
  localparam int NIB_SRC = 2;
  localparam int NIB_MHI = 1;
  localparam int NIB_MLO = 0;
  localparam int MODE_NIB1 = 4;
  localparam int MODE_NIB0 = 0;
  localparam int DIV_SEL1 = 4;
  localparam int DIV_SEL0 = 3;
  // ********************
  // Tick dividers
  // ********************
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  // ********************
  // Modes and carriers
  // ********************
  typedef enum logic [1:0] {
    MODE_13 = 2'b00,
    MODE_16 = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } dtc_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtc_sfr_req_t;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_cnt_t;
  typedef struct packed {
    logic ovf;
    dtc_cnt_t cnt;
  } dtc_step_t;
endpackage

// ===== core/dtc_timer.sv
// Dual timer/counter with mode, control and divider registers
`timescale 1ns/1ps
`default_nettype none
module dtc_timer (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire dtc_pkg::dtc_sfr_req_t sfr_req_i,
  input wire logic gate_pin_zero_i,
  input wire logic gate_pin_one_i,
  input wire logic count_pin_zero_i,
  input wire logic count_pin_one_i,
  output logic [7:0] sfr_rdata_o,
  output logic overflow_flag_zero_o,
  output logic overflow_flag_one_o
);
  // ********************
  // Registers
  // ********************
  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] div_q;
  logic [7:0] rdata_q;
  logic [3:0] presc_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  dtc_pkg::dtc_cnt_t c0_q;
  dtc_pkg::dtc_cnt_t c1_q;
  dtc_pkg::dtc_cnt_t c0_d;
  dtc_pkg::dtc_cnt_t c1_d;
  dtc_pkg::dtc_step_t r0;
  dtc_pkg::dtc_step_t r1;
  logic [3:0] nib0;
  logic [3:0] nib1;
  logic [1:0] m0;
  logic [1:0] m1;
  logic [1:0] fall;
  logic tick_fast;
  logic tick_slow;
  logic tick_sel0;
  logic tick_sel1;
  logic src0;
  logic src1;
  logic run0;
  logic run1;
  logic split;
  logic inc_lo0;
  logic inc_hi0;
  logic inc1;
  logic set_ovf0;
  logic set_ovf1;
  logic wr_any;

  // ********************
  // Step function
  // ********************
  function automatic dtc_pkg::dtc_step_t step_f(input logic [1:0] m,
    input dtc_pkg::dtc_cnt_t c);
    dtc_pkg::dtc_step_t r;
    r.cnt = c;
    r.ovf = 1'b0;
    unique case (m)
      dtc_pkg::MODE_13:
      begin
        if (c.lo[4:0] == 5'h1F)
        begin
          r.cnt.lo[4:0] = 5'h00;
          r.cnt.hi = c.hi + 8'h01;
          r.ovf = (c.hi == 8'hFF);
        end
        else
        begin
          r.cnt.lo[4:0] = c.lo[4:0] + 5'h01;
        end
      end
      dtc_pkg::MODE_16:
      begin
        r.cnt = c + 16'h0001;
        r.ovf = (c == 16'hFFFF);
      end
      dtc_pkg::MODE_RELOAD:
      begin
        r.cnt.lo = (c.lo == 8'hFF) ? c.hi : c.lo + 8'h01;
        r.ovf = (c.lo == 8'hFF);
      end
      dtc_pkg::MODE_SPLIT:
      begin
        r.cnt.lo = c.lo + 8'h01;
        r.ovf = (c.lo == 8'hFF);
      end
    endcase
    return r;
  endfunction

  // ********************
  // Ticks and pins
  // ********************
  assign nib0 = mode_q[dtc_pkg::MODE_NIB0 +: 4];
  assign nib1 = mode_q[dtc_pkg::MODE_NIB1 +: 4];
  assign m0 = nib0[dtc_pkg::NIB_MHI:dtc_pkg::NIB_MLO];
  assign m1 = nib1[dtc_pkg::NIB_MHI:dtc_pkg::NIB_MLO];
  assign run0 = ctrl_q[dtc_pkg::CTRL_RUN0];
  assign run1 = ctrl_q[dtc_pkg::CTRL_RUN1];
  assign split = (m0 == dtc_pkg::MODE_SPLIT);
  assign tick_fast = (presc_q[1:0] == 2'h3);
  assign tick_slow = (presc_q == 4'(dtc_pkg::DIV_SLOW - 1));
  assign tick_sel0 = div_q[dtc_pkg::DIV_SEL0] ? tick_fast : tick_slow;
  assign tick_sel1 = div_q[dtc_pkg::DIV_SEL1] ? tick_fast : tick_slow;
  assign fall = pin_s3_q & ~pin_s2_q;
  assign src0 = nib0[dtc_pkg::NIB_SRC] ? fall[0] : tick_sel0;
  assign src1 = nib1[dtc_pkg::NIB_SRC] ? fall[1] : tick_sel1;
  assign inc_lo0 = run0 && src0 &&
    (!nib0[dtc_pkg::NIB_GATE] || gate_pin_zero_i);
  assign inc_hi0 = split && run1 && tick_sel0;
  assign inc1 = (m1 != dtc_pkg::MODE_SPLIT) && src1 && (split ||
    (run1 && (!nib1[dtc_pkg::NIB_GATE] || gate_pin_one_i)));
  assign wr_any = sfr_req_i.wr;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      presc_q <= 4'h0;
    else if (presc_q == 4'(dtc_pkg::DIV_SLOW - 1))
      presc_q <= 4'h0;
    else
      presc_q <= presc_q + 4'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= {count_pin_one_i, count_pin_zero_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ********************
  // Counter next state
  // ********************
  always_comb
  begin
    r0 = step_f(m0, c0_q);
    r1 = step_f(m1, c1_q);
    c0_d = c0_q;
    c1_d = c1_q;
    set_ovf0 = 1'b0;
    set_ovf1 = 1'b0;
    if (inc_lo0)
    begin
      c0_d = r0.cnt;
      set_ovf0 = r0.ovf;
    end
    if (inc_hi0)
    begin
      c0_d.hi = c0_q.hi + 8'h01;
      set_ovf1 = (c0_q.hi == 8'hFF);
    end
    if (inc1)
    begin
      c1_d = r1.cnt;
      set_ovf1 = set_ovf1 || (r1.ovf && !split);
    end
    if (wr_any && sfr_req_i.addr == dtc_pkg::ADDR_LO0)
      c0_d.lo = sfr_req_i.wdata;
    if (wr_any && sfr_req_i.addr == dtc_pkg::ADDR_HI0)
      c0_d.hi = sfr_req_i.wdata;
    if (wr_any && sfr_req_i.addr == dtc_pkg::ADDR_LO1)
      c1_d.lo = sfr_req_i.wdata;
    if (wr_any && sfr_req_i.addr == dtc_pkg::ADDR_HI1)
      c1_d.hi = sfr_req_i.wdata;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      c0_q <= {dtc_pkg::CNT_RST, dtc_pkg::CNT_RST};
      c1_q <= {dtc_pkg::CNT_RST, dtc_pkg::CNT_RST};
    end
    else
    begin
      c0_q <= c0_d;
      c1_q <= c1_d;
    end
  end

  // ********************
  // Control registers
  // ********************
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      ctrl_q <= dtc_pkg::CTRL_RST;
    else
    begin
      if (wr_any && sfr_req_i.addr == dtc_pkg::ADDR_CTRL)
        ctrl_q[7:4] <= sfr_req_i.wdata[7:4];
      if (set_ovf0)
        ctrl_q[dtc_pkg::CTRL_OVF0] <= 1'b1;
      if (set_ovf1)
        ctrl_q[dtc_pkg::CTRL_OVF1] <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      mode_q <= dtc_pkg::MODE_RST;
    else if (wr_any && sfr_req_i.addr == dtc_pkg::ADDR_MODE)
      mode_q <= sfr_req_i.wdata;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      div_q <= dtc_pkg::DIV_RST;
    else if (wr_any && sfr_req_i.addr == dtc_pkg::ADDR_DIV)
    begin
      div_q[dtc_pkg::DIV_SEL1] <= sfr_req_i.wdata[dtc_pkg::DIV_SEL1];
      div_q[dtc_pkg::DIV_SEL0] <= sfr_req_i.wdata[dtc_pkg::DIV_SEL0];
    end
  end

  // ********************
  // Read path
  // ********************
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      rdata_q <= 8'h00;
    else if (sfr_req_i.rd)
    begin
      unique case (sfr_req_i.addr)
        dtc_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
        dtc_pkg::ADDR_MODE: rdata_q <= mode_q;
        dtc_pkg::ADDR_LO0: rdata_q <= c0_q.lo;
        dtc_pkg::ADDR_LO1: rdata_q <= c1_q.lo;
        dtc_pkg::ADDR_HI0: rdata_q <= c0_q.hi;
        dtc_pkg::ADDR_HI1: rdata_q <= c1_q.hi;
        dtc_pkg::ADDR_DIV: rdata_q <= div_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign overflow_flag_zero_o = ctrl_q[dtc_pkg::CTRL_OVF0];
  assign overflow_flag_one_o = ctrl_q[dtc_pkg::CTRL_OVF1];

  // ********************
  // Assertions
  // ********************
  default clocking dtc_cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_MODE13_CARRY: assert property (
    inc_lo0 && m0 == dtc_pkg::MODE_13 && c0_q.lo[4:0] == 5'h1F && !wr_any
    |=> c0_q.lo[4:0] == 5'h00 && c0_q.hi == $past(c0_q.hi) + 8'h01)
    else $error("mode 0 carry wrong");
  AST_MODE13_OVF: assert property (
    inc_lo0 && m0 == dtc_pkg::MODE_13 && c0_q.hi == 8'hFF &&
    c0_q.lo[4:0] == 5'h1F && !wr_any
    |=> ctrl_q[dtc_pkg::CTRL_OVF0] && c0_q.hi == 8'h00)
    else $error("mode 0 overflow missed");
  AST_MODE16_OVF: assert property (
    inc_lo0 && m0 == dtc_pkg::MODE_16 && c0_q == 16'hFFFF && !wr_any
    |=> c0_q == 16'h0000 && ctrl_q[dtc_pkg::CTRL_OVF0])
    else $error("mode 1 overflow missed");
  AST_RELOAD: assert property (
    inc_lo0 && m0 == dtc_pkg::MODE_RELOAD && c0_q.lo == 8'hFF && !wr_any
    |=> c0_q.lo == $past(c0_q.hi) && $stable(c0_q.hi) &&
    ctrl_q[dtc_pkg::CTRL_OVF0])
    else $error("reload wrong");
  AST_RUN_STOP: assert property (
    !run0 && !wr_any |=> $stable(c0_q.lo))
    else $error("counter 0 moved while stopped");
  AST_GATE_LOW: assert property (
    nib0[dtc_pkg::NIB_GATE] && !gate_pin_zero_i && !wr_any
    |=> $stable(c0_q.lo))
    else $error("gated counter moved");
  AST_C1_FROZEN: assert property (
    m1 == dtc_pkg::MODE_SPLIT && !wr_any |=> $stable(c1_q))
    else $error("counter 1 moved in mode 3");
  AST_SPLIT_HI: assert property (
    split && run1 && tick_sel0 && c0_q.hi == 8'hFF && !wr_any
    |=> c0_q.hi == 8'h00 && ctrl_q[dtc_pkg::CTRL_OVF1])
    else $error("split high byte overflow wrong");
  AST_SPLIT_C1: assert property (
    split && !nib1[dtc_pkg::NIB_SRC] && m1 == dtc_pkg::MODE_16 &&
    tick_sel1 && !wr_any |=> c1_q == $past(c1_q) + 16'h0001)
    else $error("counter 1 idle during split");
  AST_EXT_EDGE: assert property (
    nib0[dtc_pkg::NIB_SRC] && !nib0[dtc_pkg::NIB_GATE] && run0 &&
    m0 == dtc_pkg::MODE_16 && pin_s3_q[0] && !pin_s2_q[0] && !wr_any
    |=> c0_q == $past(c0_q) + 16'h0001)
    else $error("count pin edge missed");
  AST_SLOW_TICK: assert property (
    tick_slow |=> !tick_slow [*8] ##1 !tick_slow [*3] ##1 tick_slow)
    else $error("slow tick period wrong");
  AST_SET_WINS: assert property (
    set_ovf0 |=> ctrl_q[dtc_pkg::CTRL_OVF0])
    else $error("overflow flag lost");
endmodule
`default_nettype wire

// ===== tb/dtc_pin_model.sv
// Model of the external gate and count pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input wire logic mclk_i,
  output logic gate_pin_zero_o,
  output logic gate_pin_one_o,
  output logic count_pin_zero_o,
  output logic count_pin_one_o
);
  initial
  begin
    gate_pin_zero_o = 1'b0;
    gate_pin_one_o = 1'b0;
    count_pin_zero_o = 1'b1;
    count_pin_one_o = 1'b1;
  end
  // Gate levels change off the sampling edge
  task automatic set_gate(input logic g0, input logic g1);
    @(negedge mclk_i);
    gate_pin_zero_o = g0;
    gate_pin_one_o = g1;
  endtask
  // Falling pulses, wide enough for the synchroniser
  task automatic pulse(input int sel, input int n);
    repeat (n)
    begin
      @(negedge mclk_i);
      if (sel == 0) count_pin_zero_o = 1'b0;
      else count_pin_one_o = 1'b0;
      repeat (3) @(negedge mclk_i);
      count_pin_zero_o = 1'b1;
      count_pin_one_o = 1'b1;
      repeat (3) @(negedge mclk_i);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_dtc_timer.sv
// Testbench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_dtc_timer;
  logic mclk_i;
  logic nrst_i;
  dtc_pkg::dtc_sfr_req_t req;
  logic gate0;
  logic gate1;
  logic cnt0;
  logic cnt1;
  logic [7:0] rdata;
  logic ovf0;
  logic ovf1;
  logic [7:0] d;
  int num_errors = 0;
  int n_compared = 0;
  dtc_timer i_dtc_timer (.mclk_i(mclk_i), .nrst_i(nrst_i), .sfr_req_i(req),
    .gate_pin_zero_i(gate0), .gate_pin_one_i(gate1),
    .count_pin_zero_i(cnt0), .count_pin_one_i(cnt1), .sfr_rdata_o(rdata),
    .overflow_flag_zero_o(ovf0), .overflow_flag_one_o(ovf1));
  dtc_pin_model i_dtc_pin_model (.mclk_i(mclk_i), .gate_pin_zero_o(gate0),
    .gate_pin_one_o(gate1), .count_pin_zero_o(cnt0),
    .count_pin_one_o(cnt1));
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // ********************
  // Bus tasks
  // ********************
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk_i);
    req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(negedge mclk_i);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk_i);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge mclk_i);
    req.rd = 1'b0;
    @(negedge mclk_i);
    v = rdata;
  endtask
  task automatic chkr(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  task automatic finish_test;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    finish_test;
  end
  // ********************
  // Test sequence
  // ********************
  initial
  begin
    req = '0;
    nrst_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 7; i++) chkr(8'h88 + 8'(i), 8'h00);
    chkr(8'h80, 8'h00);
    wr(8'h89, 8'hA5);
    chkr(8'h89, 8'hA5);
    // Mode 0 from 1FFF, upper low bits kept
    wr(8'h89, 8'h04);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFF);
    wr(8'h88, 8'h10);
    i_dtc_pin_model.pulse(0, 1);
    chkr(8'h8C, 8'h00);
    chkr(8'h8A, 8'hE0);
    chkr(8'h88, 8'h30);
    `CHK(ovf0, 1'b1)
    // Mode 1 rollover from FFFF
    wr(8'h88, 8'h10);
    wr(8'h89, 8'h05);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFE);
    i_dtc_pin_model.pulse(0, 1);
    chkr(8'h8A, 8'hFF);
    `CHK(ovf0, 1'b0)
    i_dtc_pin_model.pulse(0, 1);
    chkr(8'h8C, 8'h00);
    `CHK(ovf0, 1'b1)
    // Mode 2 reload
    wr(8'h88, 8'h10);
    wr(8'h89, 8'h06);
    wr(8'h8C, 8'hFD);
    wr(8'h8A, 8'hFE);
    i_dtc_pin_model.pulse(0, 2);
    chkr(8'h8A, 8'hFD);
    chkr(8'h8C, 8'hFD);
    chkr(8'h88, 8'h30);
    // Gate and run control
    wr(8'h88, 8'h10);
    wr(8'h89, 8'h0D);
    wr(8'h8A, 8'h00);
    i_dtc_pin_model.pulse(0, 2);
    chkr(8'h8A, 8'h00);
    i_dtc_pin_model.set_gate(1'b1, 1'b0);
    i_dtc_pin_model.pulse(0, 2);
    chkr(8'h8A, 8'h02);
    i_dtc_pin_model.set_gate(1'b0, 1'b0);
    wr(8'h89, 8'h05);
    i_dtc_pin_model.pulse(0, 1);
    chkr(8'h8A, 8'h03);
    wr(8'h88, 8'h00);
    i_dtc_pin_model.pulse(0, 1);
    chkr(8'h8A, 8'h03);
    // Split mode, low byte on run zero
    wr(8'h89, 8'h07);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'h00);
    wr(8'h88, 8'h40);
    i_dtc_pin_model.pulse(0, 1);
    chkr(8'h8A, 8'hFF);
    wr(8'h88, 8'h50);
    i_dtc_pin_model.pulse(0, 1);
    chkr(8'h8A, 8'h00);
    chkr(8'h88, 8'h70);
    // Split high byte on run one
    wr(8'h88, 8'h00);
    wr(8'h8C, 8'hFE);
    wr(8'h88, 8'h40);
    repeat (40) @(negedge mclk_i);
    `CHK(ovf1, 1'b1)
    // Counter 1 free running, then frozen
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h17);
    wr(8'h8B, 8'h00);
    wr(8'h8D, 8'h00);
    repeat (120) @(negedge mclk_i);
    rd(8'h8B, d);
    `CHK(d inside {[8'h09:8'h0C]}, 1'b1)
    wr(8'h89, 8'h37);
    rd(8'h8B, d);
    repeat (120) @(negedge mclk_i);
    chkr(8'h8B, d);
    // Tick rate for both divider settings
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h89, 8'h01);
      wr(8'h8E, k ? 8'h08 : 8'h00);
      wr(8'h8A, 8'h00);
      wr(8'h88, 8'h10);
      repeat (120) @(negedge mclk_i);
      wr(8'h88, 8'h00);
      rd(8'h8A, d);
      if (k == 0) `CHK(d inside {[8'h09:8'h0B]}, 1'b1)
      else `CHK(d inside {[8'h1D:8'h20]}, 1'b1)
    end
    // Counter 1 on its own gate and count pins
    wr(8'h89, 8'hD1);
    wr(8'h8D, 8'hFF);
    wr(8'h8B, 8'hFE);
    wr(8'h88, 8'h40);
    i_dtc_pin_model.pulse(1, 1);
    chkr(8'h8B, 8'hFE);
    i_dtc_pin_model.set_gate(1'b0, 1'b1);
    i_dtc_pin_model.pulse(1, 2);
    chkr(8'h8D, 8'h00);
    chkr(8'h8B, 8'h00);
    `CHK(ovf1, 1'b1)
    chkr(8'h88, 8'hC0);
    finish_test;
  end
endmodule
`default_nettype wire
